//--- common/rxcfg_pkg.sv
package rxcfg_pkg;
   // clock and time base
   localparam int CLK_HZ = 40000000;
   localparam int FC_HZ = 13560000;
   localparam int ETU_FC_CYCLES = 128;
   localparam int QETU_CYCLES = ((ETU_FC_CYCLES / 4) * CLK_HZ) / FC_HZ;
   localparam int SQ_DELAY_NS = 18880;
   localparam int SQ_DELAY_CYCLES = (SQ_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int SC_PULSE_LIMIT = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EMD = 8'h05;
   localparam logic [7:0] IDX_SST = 8'h06;
   localparam logic [7:0] IDX_RC1 = 8'h0b;
   localparam logic [7:0] IDX_RC2 = 8'h0c;
   localparam logic [7:0] IDX_SQT = 8'h0f;
   localparam logic [7:0] IDX_STAT = 8'h10;
   // reset values
   localparam logic [7:0] RST_EMD = 8'h00;
   localparam logic [4:0] RST_SST = 5'h00;
   localparam logic [7:0] RST_RC1 = 8'h00;
   localparam logic [7:0] RST_RC2 = 8'h2c;
   localparam logic [7:0] RST_SQT = 8'h00;
   // field positions
   localparam int SST_W = 5;
   localparam int EMD_EN_BIT = 7;
   localparam int EMD_THLD_MSB = 3;
   localparam int RC1_CH_BIT = 7;
   localparam int RC1_LP_MSB = 6;
   localparam int RC1_LP_LSB = 4;
   localparam int RC1_ZA_BIT = 3;
   localparam int RC1_ZB_BIT = 2;
   localparam int RC1_ZC_BIT = 1;
   localparam int RC1_ZD_BIT = 0;
   localparam int RC2_IQ_BIT = 7;
   localparam int RC2_AMD_BIT = 6;
   localparam int RC2_SQDYN_BIT = 5;
   localparam int RC2_SQR_BIT = 4;
   localparam int RC2_AGCEN_BIT = 3;
   localparam int RC2_AGCM_BIT = 2;
   localparam int RC2_AGCALG_BIT = 1;
   localparam int RC2_AGCTRG_BIT = 0;
   localparam int STAT_SQ_BIT = 0;
   localparam int STAT_WIN_BIT = 1;
   localparam int STAT_AGC_BIT = 2;
   localparam int STAT_DROP_BIT = 3;
endpackage

//--- common/rxcfg_evt_if.sv
`timescale 1ns/1ps
interface rxcfg_evt_if;
   import rxcfg_pkg::*;
   logic mrt_expire;
   logic sc_detect;
   logic type_b_106;
   logic [SST_W-1:0] sst;
   logic emd_en;
   logic early;
   logic early_emd;
   logic window_open;
   logic tx_end;
   logic [7:0] mrt_value;
   logic [7:0] sqt;
   logic sq_dyn;
   logic squelch_on;
   modport top (output mrt_expire, sc_detect, type_b_106, sst, emd_en, tx_end, mrt_value, sqt, sq_dyn,
                input early, early_emd, window_open, squelch_on);
   modport sst_chk (input mrt_expire, sc_detect, type_b_106, sst, emd_en, output early, early_emd, window_open);
   modport sq_ctl (input tx_end, mrt_value, sqt, sq_dyn, output squelch_on);
endinterface

//--- design/rxcfg_sst_check.sv
`timescale 1ns/1ps
module rxcfg_sst_check
   import rxcfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   rxcfg_evt_if.sst_chk ev
);
   logic [6:0] tick_reg, tick_next;
   logic [SST_W:0] qcnt_reg, qcnt_next;
   logic open_reg, open_next;
   logic early_reg, early_next;
   logic emd_reg, emd_next;

   // quarter-etu elapsed count from rx mask timer expiry to subcarrier detection
   always_comb
   begin
      tick_next = tick_reg;
      qcnt_next = qcnt_reg;
      open_next = open_reg;
      early_next = 1'b0;
      emd_next = 1'b0;
      if (ev.mrt_expire)
      begin
         open_next = 1'b1;
         tick_next = '0;
         qcnt_next = '0;
      end
      else if (open_reg)
      begin
         if (ev.sc_detect)
         begin
            open_next = 1'b0;
            // early subcarrier, 106 kb/s type B only
            early_next = ev.type_b_106 && (qcnt_reg < {1'b0, ev.sst});
            emd_next = ev.type_b_106 && (qcnt_reg < {1'b0, ev.sst}) && ev.emd_en;
         end
         else if (tick_reg == 7'(QETU_CYCLES - 1))
         begin
            tick_next = '0;
            if (!qcnt_reg[SST_W])
               qcnt_next = qcnt_reg + 1'b1; // one step per quarter etu
         end
         else
            tick_next = tick_reg + 1'b1;
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_reg <= '0;
         qcnt_reg <= '0;
         open_reg <= 1'b0;
         early_reg <= 1'b0;
         emd_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= tick_next;
         qcnt_reg <= qcnt_next;
         open_reg <= open_next;
         early_reg <= early_next;
         emd_reg <= emd_next;
      end
   end

   assign ev.early = early_reg;
   assign ev.early_emd = emd_reg;
   assign ev.window_open = open_reg;
endmodule // rxcfg_sst_check

//--- design/rxcfg_squelch.sv
`timescale 1ns/1ps
module rxcfg_squelch
   import rxcfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   rxcfg_evt_if.sq_ctl ev
);
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_WAIT = 3'b010,
      SQ_ON = 3'b100
   } rxcfg_sq_state_t;

   rxcfg_sq_state_t state_reg, state_next;
   logic [9:0] cnt_reg, cnt_next;

   // dynamic squelch: delay after end of tx, release at programmed mask timer value
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         SQ_IDLE:
         begin
            if (ev.tx_end && ev.sq_dyn)
            begin
               state_next = SQ_WAIT;
               cnt_next = '0;
            end
         end
         SQ_WAIT:
         begin
            if (!ev.sq_dyn)
               state_next = SQ_IDLE;
            else if (cnt_reg == 10'(SQ_DELAY_CYCLES - 1))
               state_next = SQ_ON;
            else
               cnt_next = cnt_reg + 1'b1;
         end
         SQ_ON:
         begin
            if (!ev.sq_dyn || ev.mrt_value >= ev.sqt)
               state_next = SQ_IDLE;
         end
         default:
            state_next = SQ_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= SQ_IDLE;
         cnt_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // one-hot code: the SQ_ON bit is the flop itself, no decode on the way out
   assign ev.squelch_on = state_reg[2];
endmodule // rxcfg_squelch

//--- design/rxcfg_top.sv
// How it works
// - five-bit start time, quarter etu steps
// - early subcarrier at type B 106k: soft error
// - EMD enabled: drop early frame, raise restart
// - channel bit: 0 AM, 1 PM
// - low-pass and zero bits passed straight out
// - demod mode and AM demodulator select bits
// - squelch on after delay, off at timer
// - squelch ratio bit: 1 or 6/3
// - AGC mode: first eight pulses or whole
// - AGC algorithm bit: preset or reset
// - AGC trigger bit: ratio 3 or 6
// - EMD frame-error drop only below byte threshold
`timescale 1ns/1ps
module rxcfg_top
   import rxcfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_end,
   input wire logic mrt_expire,
   input wire logic [7:0] rx_mask_timer,
   input wire logic sc_detect,
   input wire logic sc_pulse,
   input wire logic rx_start,
   input wire logic rx_type_b_106,
   input wire logic rx_frame_end,
   input wire logic rx_frame_error,
   input wire logic [8:0] rx_byte_count,
   output logic rx_channel_pick,
   output logic [2:0] lowpass_sel,
   output logic zero_cfg_a,
   output logic zero_cfg_b,
   output logic zero_cfg_c,
   output logic zero_cfg_d,
   output logic demod_iq,
   output logic amd_mixer,
   output logic squelch_ratio_hi,
   output logic squelch_on,
   output logic agc_enable,
   output logic agc_adjust,
   output logic agc_reset_alg,
   output logic gain_trigger_level,
   output logic soft_error_irq,
   output logic restart_irq,
   output logic frame_drop
);
   logic [7:0] emd_reg, emd_next;
   logic [SST_W-1:0] sst_reg, sst_next;
   logic [7:0] rc1_reg, rc1_next;
   logic [7:0] rc2_reg, rc2_next;
   logic [7:0] sqt_reg, sqt_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [3:0] scp_reg, scp_next;
   logic agc_adj_reg, agc_adj_next;
   logic soft_reg, soft_next;
   logic restart_reg, restart_next;
   logic drop_reg, drop_next;
   logic dropped_reg, dropped_next;
   logic sq_reg;
   logic setup_ph;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] stat_val;

   rxcfg_evt_if ev ();

   // byte address to register index, low two bits must be zero
   function automatic logic [8:0] reg_index(input logic [11:0] a);
      reg_index = {(a[1:0] != 2'b00), a[9:2]};
   endfunction

   // index is mapped when aligned and listed
   function automatic logic idx_hit(input logic [8:0] i);
      idx_hit = (i == {1'b0, IDX_EMD}) || (i == {1'b0, IDX_SST}) || (i == {1'b0, IDX_RC1}) ||
                (i == {1'b0, IDX_RC2}) || (i == {1'b0, IDX_SQT}) || (i == {1'b0, IDX_STAT});
   endfunction

   // event and configuration hookup of the two sub-blocks
   assign ev.mrt_expire = mrt_expire;
   assign ev.sc_detect = sc_detect;
   assign ev.type_b_106 = rx_type_b_106;
   assign ev.sst = sst_reg;
   assign ev.emd_en = emd_reg[EMD_EN_BIT];
   assign ev.tx_end = tx_end;
   assign ev.mrt_value = rx_mask_timer;
   assign ev.sqt = sqt_reg;
   assign ev.sq_dyn = rc2_reg[RC2_SQDYN_BIT];

   rxcfg_sst_check u_sst (
      .pclk (pclk),
      .presetn (presetn),
      .ev (ev.sst_chk)
   );

   rxcfg_squelch u_sq (
      .pclk (pclk),
      .presetn (presetn),
      .ev (ev.sq_ctl)
   );

   assign sq_reg = ev.squelch_on;

   // apb phase decode; writes land at the access edge where pready is high
   assign setup_ph = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready_reg && !pslverr_reg && pstrb[0];
   assign wbyte = pwdata[7:0];

   // live state for the status word
   always_comb
   begin
      stat_val = 8'h00;
      stat_val[STAT_SQ_BIT] = sq_reg;
      stat_val[STAT_WIN_BIT] = ev.window_open;
      stat_val[STAT_AGC_BIT] = agc_adj_reg;
      stat_val[STAT_DROP_BIT] = dropped_reg;
   end

   // apb slave: answer prepared in setup, given with pready in access
   always_comb
   begin
      pready_next = setup_ph;
      pslverr_next = 1'b0;
      prdata_next = prdata_reg;
      if (setup_ph)
      begin
         pslverr_next = !idx_hit(reg_index(paddr)) || (pwrite && reg_index(paddr) == {1'b0, IDX_STAT});
         prdata_next = 32'h0000_0000;
         if (!pwrite)
         begin
            unique case (reg_index(paddr))
               {1'b0, IDX_EMD}: prdata_next[7:0] = emd_reg;
               {1'b0, IDX_SST}: prdata_next[7:0] = {3'h0, sst_reg};
               {1'b0, IDX_RC1}: prdata_next[7:0] = rc1_reg;
               {1'b0, IDX_RC2}: prdata_next[7:0] = rc2_reg;
               {1'b0, IDX_SQT}: prdata_next[7:0] = sqt_reg;
               {1'b0, IDX_STAT}: prdata_next[7:0] = stat_val;
               default: prdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // configuration registers
   always_comb
   begin
      emd_next = emd_reg;
      sst_next = sst_reg;
      rc1_next = rc1_reg;
      rc2_next = rc2_reg;
      sqt_next = sqt_reg;
      if (wr_en)
      begin
         unique case (reg_index(paddr))
            {1'b0, IDX_EMD}: emd_next = {wbyte[EMD_EN_BIT], 3'h0, wbyte[EMD_THLD_MSB:0]};
            {1'b0, IDX_SST}: sst_next = wbyte[SST_W-1:0];
            {1'b0, IDX_RC1}: rc1_next = wbyte;
            {1'b0, IDX_RC2}: rc2_next = wbyte;
            {1'b0, IDX_SQT}: sqt_next = wbyte;
            default: sqt_next = sqt_reg;
         endcase
      end
   end

   // agc window: counts subcarrier pulses per reception
   always_comb
   begin
      scp_next = scp_reg;
      if (rx_start || mrt_expire)
         scp_next = 4'h0;
      else if (sc_pulse && scp_reg != 4'(SC_PULSE_LIMIT))
         scp_next = scp_reg + 1'b1;
      // mode 0 limits adjustment to first eight pulses
      agc_adj_next = rc2_reg[RC2_AGCEN_BIT] &&
                     (rc2_reg[RC2_AGCM_BIT] || scp_next != 4'(SC_PULSE_LIMIT));
   end

   // error events: early subcarrier and short erroneous frames
   always_comb
   begin
      soft_next = ev.early;
      restart_next = ev.early_emd;
      drop_next = ev.early_emd;
      dropped_next = dropped_reg;
      if (rx_frame_end && rx_frame_error && emd_reg[EMD_EN_BIT] &&
          rx_byte_count < {5'h00, emd_reg[EMD_THLD_MSB:0]})
      begin
         restart_next = 1'b1;
         drop_next = 1'b1;
      end
      if (drop_next)
         dropped_next = 1'b1;
      else if (rx_start)
         dropped_next = 1'b0;
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         emd_reg <= RST_EMD;
         sst_reg <= RST_SST;
         rc1_reg <= RST_RC1;
         rc2_reg <= RST_RC2;
         sqt_reg <= RST_SQT;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         scp_reg <= 4'h0;
         agc_adj_reg <= 1'b0;
         soft_reg <= 1'b0;
         restart_reg <= 1'b0;
         drop_reg <= 1'b0;
         dropped_reg <= 1'b0;
      end
      else
      begin
         emd_reg <= emd_next;
         sst_reg <= sst_next;
         rc1_reg <= rc1_next;
         rc2_reg <= rc2_next;
         sqt_reg <= sqt_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         scp_reg <= scp_next;
         agc_adj_reg <= agc_adj_next;
         soft_reg <= soft_next;
         restart_reg <= restart_next;
         drop_reg <= drop_next;
         dropped_reg <= dropped_next;
      end
   end

   // bus outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // analog front end settings, driven unchanged from the registers except squelch_on and agc_adjust
   assign rx_channel_pick = rc1_reg[RC1_CH_BIT];
   assign lowpass_sel = rc1_reg[RC1_LP_MSB:RC1_LP_LSB];
   assign zero_cfg_a = rc1_reg[RC1_ZA_BIT];
   assign zero_cfg_b = rc1_reg[RC1_ZB_BIT];
   assign zero_cfg_c = rc1_reg[RC1_ZC_BIT];
   assign zero_cfg_d = rc1_reg[RC1_ZD_BIT];
   assign demod_iq = rc2_reg[RC2_IQ_BIT];
   assign amd_mixer = rc2_reg[RC2_AMD_BIT];
   assign squelch_ratio_hi = rc2_reg[RC2_SQR_BIT];
   assign squelch_on = sq_reg;
   assign agc_enable = rc2_reg[RC2_AGCEN_BIT];
   assign agc_adjust = agc_adj_reg;
   assign agc_reset_alg = rc2_reg[RC2_AGCALG_BIT];
   assign gain_trigger_level = rc2_reg[RC2_AGCTRG_BIT];

   // event pulses
   assign soft_error_irq = soft_reg;
   assign restart_irq = restart_reg;
   assign frame_drop = drop_reg;
endmodule // rxcfg_top

//--- dv/rxcfg_sva.sv
`timescale 1ns/1ps
module rxcfg_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input logic [31:0] prdata,
   input logic pready,
   input wire logic tx_end,
   input wire logic sc_detect,
   input wire logic rx_type_b_106,
   input logic rx_channel_pick,
   input logic [2:0] lowpass_sel,
   input logic demod_iq,
   input logic agc_enable,
   input logic gain_trigger_level,
   input logic squelch_on,
   input logic agc_adjust,
   input logic soft_error_irq,
   input logic restart_irq,
   input logic frame_drop
);
   logic wr_ok;
   logic [9:0] gap_reg;
   logic [9:0] gap_next;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // committed byte write
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
   // cycles since the last end of transmission, saturating
   always_comb
      gap_next = tx_end ? 10'h001 : ((gap_reg == 10'h3ff) ? gap_reg : gap_reg + 10'h001);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         gap_reg <= 10'h3ff;
      else
         gap_reg <= gap_next;
   property p_rc1; wr_ok && paddr == 12'h02c |=> {rx_channel_pick, lowpass_sel} == $past(pwdata[7:4]); endproperty
   a_rc1: assert property (p_rc1) else $error("channel or low-pass output wrong");
   property p_rc2; wr_ok && paddr == 12'h030 |=> {demod_iq, agc_enable, gain_trigger_level} ==
      {$past(pwdata[7]), $past(pwdata[3]), $past(pwdata[0])}; endproperty
   a_rc2: assert property (p_rc2) else $error("receiver mode outputs wrong");
   property p_sst_rd; psel && penable && pready && !pwrite && paddr == 12'h018 |-> prdata[31:5] == 27'h0; endproperty
   a_sst_rd: assert property (p_sst_rd) else $error("start timer upper bits not zero");
   property p_soft_one; soft_error_irq |=> !soft_error_irq; endproperty
   a_soft_one: assert property (p_soft_one) else $error("soft error longer than one cycle");
   property p_soft_cause; soft_error_irq |-> $past(sc_detect, 2) && $past(rx_type_b_106, 2); endproperty
   a_soft_cause: assert property (p_soft_cause) else $error("soft error without cause");
   property p_restart; restart_irq |-> frame_drop; endproperty
   a_restart: assert property (p_restart) else $error("restart without frame drop");
   property p_sq_on; $rose(squelch_on) |-> gap_reg == 10'h2f5; endproperty
   a_sq_on: assert property (p_sq_on) else $error("squelch rose at wrong time");
   property p_agc_off; !agc_enable [*2] |-> !agc_adjust; endproperty
   a_agc_off: assert property (p_agc_off) else $error("gain adjusting while disabled");
endmodule // rxcfg_sva
bind rxcfg_top rxcfg_sva u_sva (
   .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr),
   .pwdata (pwdata), .pstrb (pstrb), .prdata (prdata), .pready (pready), .tx_end (tx_end),
   .sc_detect (sc_detect), .rx_type_b_106 (rx_type_b_106), .rx_channel_pick (rx_channel_pick),
   .lowpass_sel (lowpass_sel), .demod_iq (demod_iq), .agc_enable (agc_enable),
   .gain_trigger_level (gain_trigger_level), .squelch_on (squelch_on), .agc_adjust (agc_adjust),
   .soft_error_irq (soft_error_irq), .restart_irq (restart_irq), .frame_drop (frame_drop)
);

//--- dv/rxcfg_fe_model.sv
`timescale 1ns/1ps
module rxcfg_fe_model (
   input wire logic pclk,
   output logic tx_end,
   output logic mrt_expire,
   output logic sc_detect,
   output logic sc_pulse,
   output logic rx_start,
   output logic rx_frame_end,
   output logic rx_type_b_106 = 1'b0,
   output logic rx_frame_error = 1'b0,
   output logic [7:0] rx_mask_timer = 8'h00,
   output logic [8:0] rx_byte_count = 9'h000
);
   logic [5:0] pv = 6'h00;
   // one-cycle event strobes toward the receive logic
   assign {rx_frame_end, rx_start, sc_pulse, sc_detect, mrt_expire, tx_end} = pv;
   // strobe one event, entered just after an edge
   task automatic pulse(input int i);
      pv[i] <= 1'b1;
      @(posedge pclk);
      pv[i] <= 1'b0;
   endtask
   // subcarrier seen d cycles after mask timer expiry
   task automatic sc_after(input int d, input logic b106);
      rx_type_b_106 <= b106;
      pulse(1);
      repeat (d - 1) @(posedge pclk);
      pulse(2);
   endtask
   // frame end with error flag and length, both inverted afterwards
   task automatic frame(input logic err, input logic [8:0] nb);
      rx_frame_error <= err;
      rx_byte_count <= nb;
      pulse(5);
      rx_frame_error <= ~err;
      rx_byte_count <= ~nb;
   endtask
   // mask timer level
   task automatic mtimer(input logic [7:0] v);
      rx_mask_timer <= v;
   endtask
endmodule // rxcfg_fe_model

//--- dv/rxcfg_tb_top.sv
`timescale 1ns/1ps
module rxcfg_tb_top;
   import rxcfg_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rd;
   logic [2:0] lowpass_sel;
   logic [7:0] rx_mask_timer;
   logic [8:0] rx_byte_count;
   logic pready, pslverr, er, tx_end, mrt_expire, sc_detect, sc_pulse, rx_start, rx_type_b_106, rx_frame_end;
   logic rx_frame_error, rx_channel_pick, zero_cfg_a, zero_cfg_b, zero_cfg_c, zero_cfg_d, demod_iq, amd_mixer;
   logic squelch_ratio_hi, squelch_on, agc_enable, agc_adjust, agc_reset_alg, gain_trigger_level;
   logic soft_error_irq, restart_irq, frame_drop;
   int miscompares = 0;
   int n_checks = 0;
   int nse = 0;
   int nrs = 0;
   int ndr = 0;
   int n, s, r;
   rxcfg_fe_model fe (
      .pclk (pclk), .tx_end (tx_end), .mrt_expire (mrt_expire), .sc_detect (sc_detect), .sc_pulse (sc_pulse),
      .rx_start (rx_start), .rx_frame_end (rx_frame_end), .rx_type_b_106 (rx_type_b_106),
      .rx_frame_error (rx_frame_error), .rx_mask_timer (rx_mask_timer), .rx_byte_count (rx_byte_count)
   );
   rxcfg_top dut (
      .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr),
      .pwdata (pwdata), .pstrb (pstrb), .prdata (prdata), .pready (pready), .pslverr (pslverr),
      .tx_end (tx_end), .mrt_expire (mrt_expire), .rx_mask_timer (rx_mask_timer), .sc_detect (sc_detect),
      .sc_pulse (sc_pulse), .rx_start (rx_start), .rx_type_b_106 (rx_type_b_106), .rx_frame_end (rx_frame_end),
      .rx_frame_error (rx_frame_error), .rx_byte_count (rx_byte_count), .rx_channel_pick (rx_channel_pick),
      .lowpass_sel (lowpass_sel), .zero_cfg_a (zero_cfg_a), .zero_cfg_b (zero_cfg_b), .zero_cfg_c (zero_cfg_c),
      .zero_cfg_d (zero_cfg_d), .demod_iq (demod_iq), .amd_mixer (amd_mixer), .squelch_ratio_hi (squelch_ratio_hi),
      .squelch_on (squelch_on), .agc_enable (agc_enable), .agc_adjust (agc_adjust), .agc_reset_alg (agc_reset_alg),
      .gain_trigger_level (gain_trigger_level), .soft_error_irq (soft_error_irq), .restart_irq (restart_irq),
      .frame_drop (frame_drop)
   );
   // bus clock
   initial
      forever #12.5 pclk = ~pclk;
   // event pulse tallies
   always @(posedge pclk)
   begin
      nse += int'(soft_error_irq === 1'b1);
      nrs += int'(restart_irq === 1'b1);
      ndr += int'(frame_drop === 1'b1);
   end
   task automatic print_verdict;
      if (miscompares == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic to_end;
      miscompares++;
      print_verdict;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one transfer and an idle cycle; answer in rd and er
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
         to_end;
      @(posedge pclk);
   endtask
   task automatic t_reset;
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'(RST_SST));
      apb(1'b0, 12'h02c, 32'h0);
      chk(rd, 32'(RST_RC1));
      apb(1'b0, 12'h030, 32'h0);
      chk(rd, 32'(RST_RC2));
   endtask
   // config bits reach outputs and read back
   task automatic t_cfg;
      logic [7:0] v [4] = '{8'ha5, 8'h5a, 8'hd3, 8'h2c};
      logic [11:0] a;
      for (int i = 0; i < 4; i++)
      begin
         a = (i < 2) ? 12'h02c : 12'h030;
         apb(1'b1, a, 32'(v[i]));
         apb(1'b0, a, 32'h0);
         chk(rd, 32'(v[i]));
         if (i < 2)
            chk({rx_channel_pick, lowpass_sel, zero_cfg_a, zero_cfg_b, zero_cfg_c, zero_cfg_d}, v[i]);
         else
            chk({demod_iq, amd_mixer, squelch_ratio_hi, agc_enable, agc_reset_alg, gain_trigger_level},
               {v[i][7:6], v[i][4:3], v[i][1:0]});
      end
   endtask
   // five-bit field, strobe-less write ignored, unmapped read refused
   task automatic t_sst;
      apb(1'b1, 12'h018, 32'hffffffff);
      pstrb <= 4'he;
      apb(1'b1, 12'h018, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'h1f);
      apb(1'b0, 12'h0fc, 32'h0);
      chk(er, 1'b1);
   endtask
   // early subcarrier, on time at the boundary, and not type B
   task automatic t_early;
      int dl [3] = '{QETU_CYCLES + 6, 2 * QETU_CYCLES + 6, QETU_CYCLES + 6};
      logic bt [3] = '{1'b1, 1'b1, 1'b0};
      apb(1'b1, 12'h018, 32'h2);
      for (int i = 0; i < 3; i++)
      begin
         s = nse;
         fe.sc_after(dl[i], bt[i]);
         repeat (4) @(posedge pclk);
         chk(32'(nse - s), (i == 0) ? 32'h1 : 32'h0);
      end
      chk(32'(nrs), 32'h0);
      apb(1'b1, 12'h014, 32'h84);
      s = nrs;
      r = ndr;
      fe.sc_after(dl[0], 1'b1);
      repeat (4) @(posedge pclk);
      chk(32'(nrs - s), 32'h1);
      chk(32'(ndr - r), 32'h1);
   endtask
   // short erroneous frames dropped, threshold four
   task automatic t_emd;
      logic el [3] = '{1'b1, 1'b1, 1'b0};
      logic [8:0] nb [3] = '{9'h003, 9'h004, 9'h002};
      for (int i = 0; i < 3; i++)
      begin
         r = ndr;
         fe.frame(el[i], nb[i]);
         repeat (3) @(posedge pclk);
         chk(32'(ndr - r), (i == 0) ? 32'h1 : 32'h0);
      end
   endtask
   // squelch delay after transmission, release at squelch time
   task automatic t_sq;
      apb(1'b1, 12'h03c, 32'h40);
      fe.pulse(0);
      n = 0;
      while (squelch_on !== 1'b1 && n < 900)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 900)
         to_end;
      chk(32'(n), 32'(SQ_DELAY_CYCLES + 1));
      fe.mtimer(8'h3f);
      repeat (3) @(posedge pclk);
      chk(squelch_on, 1'b1);
      fe.mtimer(8'h40);
      repeat (3) @(posedge pclk);
      chk(squelch_on, 1'b0);
   endtask
   // gain adjusting limited to first pulses in mode 0
   task automatic t_agc;
      apb(1'b1, 12'h030, 32'h28);
      fe.pulse(4);
      for (int i = 0; i <= SC_PULSE_LIMIT; i++)
      begin
         repeat (3) @(posedge pclk);
         chk(agc_adjust, (i < SC_PULSE_LIMIT) ? 1'b1 : 1'b0);
         fe.pulse(3);
      end
      apb(1'b1, 12'h030, 32'h2c);
      @(posedge pclk);
      chk(agc_adjust, 1'b1);
      apb(1'b1, 12'h030, 32'h20);
      @(posedge pclk);
      chk(agc_adjust, 1'b0);
   endtask
   // reset, then scenarios in turn
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_cfg;
      t_sst;
      t_early;
      t_emd;
      t_sq;
      t_agc;
      // let the last assertion sample before the run ends
      repeat (2) @(posedge pclk);
      print_verdict;
   end
endmodule // rxcfg_tb_top
